// file: shared/lia_defs.vh
// constants for the link interrupt aggregator
`ifndef LIA_DEFS_VH
`define LIA_DEFS_VH

// register indices, byte address is four times the index
`define LIA_IDX_W 12
`define LIA_IDX_MASK 12'h218
`define LIA_IDX_EN0 12'h219
`define LIA_IDX_ST0 12'h222
`define LIA_IDX_SUM 12'h232
`define LIA_IDX_EVT 12'h240
`define LIA_IDX_EVM 12'h241

// word index field of haddr
`define LIA_ADDR_HI 13
`define LIA_ADDR_LO 2

// htrans bit that marks NONSEQ or SEQ
`define LIA_HTRANS_ACT 1

// link status bit positions
`define LIA_ST_CNT_OVF 0
`define LIA_ST_CELL_DEL 1
`define LIA_ST_FRAME 2
`define LIA_ST_DSYNC 3
`define LIA_ST_VIOL 4
`define LIA_ST_CHG 5
`define LIA_ST_GRP_CC 6
`define LIA_ST_GRP_OVF 7

// reset values
`define LIA_RST_BYTE 8'h00
`define LIA_RST_ST 6'h00
`define LIA_RST_NIB 4'h0
`define LIA_RST_WORD 32'h0000_0000
`define LIA_RST_IDX 12'h000

`endif

// file: rtl/lia_top.v
// link interrupt aggregator with ahb-lite register slave
`include "lia_defs.vh"

module lia_top (
  // clock and reset
  input wire core_clk_i,
  input wire reset_n_i,
  // ahb-lite slave
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output wire [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  // per-link events, one bit per link
  input wire [3:0] cell_delineation_lost_i,
  input wire [3:0] frame_alignment_lost_i,
  input wire [3:0] delay_sync_lost_i,
  input wire [3:0] control_cell_violation_i,
  input wire [3:0] control_cell_change_i,
  input wire [3:0] counter_overflow_i,
  // group sources, one bit per group except the single shared overflow bit
  input wire [3:0] group_control_cell_ready_i,
  input wire [3:0] group_frame_pulse_i,
  input wire group_overflow_i,
  // interrupt outputs
  output wire irq_n_o,
  output wire irq_o
);

  // word index of an address
  function [11:0] word_idx;
    input [31:0] a;
    begin
      word_idx = a[`LIA_ADDR_HI:`LIA_ADDR_LO];
    end
  endfunction

  // bus registers
  reg [11:0] addr_q;
  reg wr_q;
  reg [31:0] hrdata_q;
  reg hreadyout_q;
  reg hresp_q;
  // control and status
  reg [7:0] mask_q;
  reg [3:0] req_q;
  reg [3:0] rdy_q;
  reg [3:0] evt_q;
  reg [3:0] evm_q;
  reg irq_n_q;
  reg irq_q;

  wire acc;
  wire rd_acc;
  wire [11:0] rd_idx;
  wire wr_mask;
  wire [31:0] en_d;
  wire [31:0] stv_d;
  wire [3:0] req_d;
  wire [7:0] mask_d;
  wire [3:0] evt_d;
  wire [3:0] evm_d;
  wire grp_cc_evt;
  reg [31:0] rd_val;

  assign acc = hsel_i & hready_i & htrans_i[`LIA_HTRANS_ACT];
  assign rd_acc = acc & ~hwrite_i;
  assign rd_idx = word_idx(haddr_i);

  // group ready rising or frame pulse
  assign grp_cc_evt = (|(group_control_cell_ready_i & ~rdy_q)) | (|group_frame_pulse_i);

  // master enable write, all eight bits kept as written
  assign wr_mask = wr_q & (addr_q == `LIA_IDX_MASK);
  assign mask_d = wr_mask ? hwdata_i[7:0] : mask_q;

  genvar l;
  generate
    for (l = 0; l < 4; l = l + 1) begin : g_link
      localparam integer EN_IDX_I = `LIA_IDX_EN0 + l;
      localparam integer ST_IDX_I = `LIA_IDX_ST0 + l;
      localparam [11:0] EN_IDX = EN_IDX_I[11:0];
      localparam [11:0] ST_IDX = ST_IDX_I[11:0];
      reg [7:0] en_q;
      reg [6:1] st_q;
      wire wr_en;
      wire wr_st;
      wire [6:1] set;
      wire [6:1] clr;
      wire [6:1] st_d;
      wire [7:0] view_d;

      assign wr_en = wr_q & (addr_q == EN_IDX);
      assign wr_st = wr_q & (addr_q == ST_IDX);
      assign en_d[l*8 +: 8] = wr_en ? hwdata_i[7:0] : en_q;

      assign set[`LIA_ST_CELL_DEL] = cell_delineation_lost_i[l];
      assign set[`LIA_ST_FRAME] = frame_alignment_lost_i[l];
      assign set[`LIA_ST_DSYNC] = delay_sync_lost_i[l];
      assign set[`LIA_ST_VIOL] = control_cell_violation_i[l];
      assign set[`LIA_ST_CHG] = control_cell_change_i[l];
      if (l == 0) begin : g_grp
        assign set[`LIA_ST_GRP_CC] = grp_cc_evt;
      end else begin : g_nogrp
        assign set[`LIA_ST_GRP_CC] = 1'b0;
      end

      // write zero clears, write one keeps, event wins
      assign clr = {6{wr_st}} & ~hwdata_i[6:1];
      assign st_d = set | (st_q & ~clr);

      if (l == 0) begin : g_view0
        assign view_d = {group_overflow_i, st_d, counter_overflow_i[l]};
      end else begin : g_view
        assign view_d = {2'b00, st_d[5:1], counter_overflow_i[l]};
      end
      assign stv_d[l*8 +: 8] = view_d;

      // request is unlatched and/or of enabled status bits
      assign req_d[l] = |(view_d & en_d[l*8 +: 8]);

      always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          en_q <= `LIA_RST_BYTE;
          st_q <= `LIA_RST_ST;
        end else begin
          en_q <= en_d[l*8 +: 8];
          st_q <= st_d;
        end
      end
    end
  endgenerate

  // own event status, set on rising link request, cleared by read
  assign evm_d = (wr_q & (addr_q == `LIA_IDX_EVM)) ? hwdata_i[3:0] : evm_q;
  assign evt_d = (req_d & ~req_q) | (evt_q & ~{4{rd_acc & (rd_idx == `LIA_IDX_EVT)}});

  // read mux sees values committed by a write in the same edge
  always @* begin
    rd_val = `LIA_RST_WORD;
    case (rd_idx)
      `LIA_IDX_MASK: rd_val[7:0] = mask_d;
      `LIA_IDX_SUM: rd_val[3:0] = req_d;
      `LIA_IDX_EVT: rd_val[3:0] = evt_q;
      `LIA_IDX_EVM: rd_val[3:0] = evm_d;
      default: begin
        if (rd_idx >= `LIA_IDX_EN0 && rd_idx < `LIA_IDX_EN0 + 12'h004) begin
          rd_val[7:0] = en_d[{rd_idx[1:0] - 2'b01, 3'b000} +: 8];
        end else if (rd_idx >= `LIA_IDX_ST0 && rd_idx < `LIA_IDX_ST0 + 12'h004) begin
          rd_val[7:0] = stv_d[{rd_idx[1:0] - 2'b10, 3'b000} +: 8];
        end
      end
    endcase
  end

  // bus slave, zero wait states, always okay
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_q <= `LIA_RST_IDX;
      wr_q <= 1'b0;
      hrdata_q <= `LIA_RST_WORD;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      wr_q <= acc & hwrite_i;
      if (acc) begin
        addr_q <= rd_idx;
      end
      if (rd_acc) begin
        hrdata_q <= rd_val;
      end
    end
  end

  // control, request history and interrupt pins
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mask_q <= `LIA_RST_BYTE;
      req_q <= `LIA_RST_NIB;
      rdy_q <= `LIA_RST_NIB;
      evt_q <= `LIA_RST_NIB;
      evm_q <= `LIA_RST_NIB;
      irq_n_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      mask_q <= mask_d;
      req_q <= req_d;
      rdy_q <= group_control_cell_ready_i;
      evt_q <= evt_d;
      evm_q <= evm_d;
      irq_n_q <= ~(|(req_d & mask_d[3:0]));
      irq_q <= |(evt_d & evm_d);
    end
  end

  assign hrdata_o = hrdata_q;
  assign hreadyout_o = hreadyout_q;
  assign hresp_o = hresp_q;
  assign irq_n_o = irq_n_q;
  assign irq_o = irq_q;

endmodule // lia_top

// file: testbench/lia_chk_sva.sv
// port checker for the link interrupt aggregator
`include "lia_defs.vh"
module lia_chk (
  input wire core_clk_i, reset_n_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o,
  input wire irq_n_o, group_overflow_i,
  input wire [1:0] htrans_i,
  input wire [31:0] haddr_i, hwdata_i, hrdata_o,
  input wire [3:0] counter_overflow_i, group_control_cell_ready_i, group_frame_pulse_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_q, wr_q, b6_q;
  logic [3:0] rdy_q, msk_q;
  logic [11:0] ix_q;
  wire [11:0] s = ix_q - `LIA_IDX_ST0;
  wire tk = hsel_i & hready_i & htrans_i[1];
  always @(posedge core_clk_i or negedge reset_n_i)
    if (!reset_n_i) {rd_q, wr_q, b6_q, rdy_q, msk_q, ix_q} <= 0;
    else begin
      {rd_q, wr_q} <= {tk & !hwrite_i, tk & hwrite_i};
      {rdy_q, ix_q} <= {group_control_cell_ready_i, haddr_i[13:2]};
      if (wr_q && ix_q == `LIA_IDX_MASK) msk_q <= hwdata_i[3:0];
      if (|{group_control_cell_ready_i & ~rdy_q, group_frame_pulse_i}) b6_q <= 1;
      else if (wr_q && s == 0 && !hwdata_i[6]) b6_q <= 0;
    end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  chk_bus_okay: assert property (hreadyout_o && !hresp_o) else $error("bus stall");
  chk_read_high: assert property (rd_q |-> hrdata_o[31:8] == 0) else $error("read high");
  chk_sum_bits: assert property (rd_q && ix_q == `LIA_IDX_SUM |-> !hrdata_o[7:4])
    else $error("summary bits");
  chk_high_links: assert property (rd_q && s inside {1, 2, 3} |-> !hrdata_o[7:6])
    else $error("link group bits");
  chk_grp_ovf: assert property (rd_q && s == 0 && $past(reset_n_i, 2) &&
    $past(group_overflow_i, 2) == $past(group_overflow_i) |->
    hrdata_o[7] == $past(group_overflow_i)) else $error("bit 7");
  chk_cnt_ovf: assert property (rd_q && s < 4 && $past(reset_n_i, 2) &&
    $past(counter_overflow_i, 2) == $past(counter_overflow_i) |->
    hrdata_o[0] == |($past(counter_overflow_i) & (4'h1 << s[1:0]))) else $error("bit 0");
  chk_mask_gate: assert property (msk_q == 0 |-> irq_n_o) else $error("masked pin");
  chk_grp_evt: assert property (rd_q && s == 0 && $stable(b6_q) |->
    hrdata_o[6] == b6_q) else $error("bit 6");
endmodule // lia_chk
bind lia_top lia_chk u_chk (.*);

// file: testbench/lia_host.sv
// host model that latches the interrupt pin
module lia_host (
  input wire core_clk_i,
  input wire reset_n_i,
  input wire irq_n_o,
  output logic seen_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge core_clk_i or negedge reset_n_i)
    if (!reset_n_i) seen_o <= 0;
    else if (!irq_n_o) seen_o <= 1;
endmodule // lia_host

// file: testbench/tb_top.sv
// bench for the link interrupt aggregator
`include "lia_defs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 0, reset_n_i = 0, hsel_i = 0, hwrite_i = 0, gov = 0;
  logic [1:0] htrans_i = 0;
  logic [31:0] haddr_i = 0, hwdata_i = 0, r, sd = 32'h7590;
  logic [19:0] ev = 0;
  logic [3:0] cnt = 0, rdy = 0, fp = 0;
  wire [31:0] hrdata_o;
  wire hr, irq_n_o, irq_o, seen;
  int n_mismatch = 0, cmp_count = 0, k, b, evt = 0;
  initial forever #12.5 core_clk_i = ~core_clk_i;
  lia_top uut (.core_clk_i, .reset_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i(3'h2), .hwdata_i, .hready_i(hr), .hrdata_o, .hreadyout_o(hr), .hresp_o(),
    .cell_delineation_lost_i(ev[3:0]), .frame_alignment_lost_i(ev[7:4]),
    .delay_sync_lost_i(ev[11:8]), .control_cell_violation_i(ev[15:12]),
    .control_cell_change_i(ev[19:16]), .counter_overflow_i(cnt), .group_overflow_i(gov),
    .group_control_cell_ready_i(rdy), .group_frame_pulse_i(fp), .irq_n_o, .irq_o);
  lia_host host (.core_clk_i, .reset_n_i, .irq_n_o, .seen_o(seen));
  task complete_run;
    if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input [31:0] e);
    cmp_count++;
    if (r !== e) begin
      n_mismatch++;
      $display("unexpected at %0t got %h want %h", $time, r, e);
    end
  endtask
  task automatic tick;
    int n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (hr !== 1 && n < 50);
    if (hr !== 1) begin
      n_mismatch++;
      complete_run;
    end
  endtask
  task bus(input w, input int ix, input [31:0] d);
    {hsel_i, htrans_i, hwrite_i} <= {3'b110, w};
    haddr_i <= ix * 4;
    tick;
    {hsel_i, htrans_i} <= 0;
    hwdata_i <= d;
    tick;
    r = hrdata_o;
  endtask
  task rd(input int ix, input [31:0] e);
    bus(0, ix, 0);
    chk(e);
  endtask
  task see(input [1:0] e);
    @(posedge core_clk_i);
    r = {irq_o, irq_n_o};
    chk(e);
  endtask
  function automatic [31:0] rnd;
    sd ^= sd << 13;
    sd ^= sd >> 17;
    sd ^= sd << 5;
    return sd;
  endfunction
  initial begin
    repeat (4) @(posedge core_clk_i);
    reset_n_i <= 1;
    rd(`LIA_IDX_MASK, 0);
    rd(`LIA_IDX_SUM, 0);
    rd(12'h3ff, 0);
    for (b = 1; b < 6; b++) begin
      k = rnd() % 4;
      evt |= 1 << k;
      bus(1, `LIA_IDX_EN0 + k, 1 << b);
      ev[4 * b - 4 + k] <= 1;
      @(posedge core_clk_i);
      ev <= 0;
      rd(`LIA_IDX_ST0 + k, 1 << b);
      rd(`LIA_IDX_SUM, 1 << k);
      bus(1, `LIA_IDX_ST0 + k, 8'hff);
      rd(`LIA_IDX_ST0 + k, 1 << b);
      bus(1, `LIA_IDX_ST0 + k, 0);
      rd(`LIA_IDX_SUM, 0);
    end
    rd(`LIA_IDX_EVT, evt);
    k = rnd() % 4;
    bus(1, `LIA_IDX_EN0 + k, 8'h08);
    bus(1, `LIA_IDX_MASK, 8'h0f ^ (1 << k));
    bus(1, `LIA_IDX_EVM, 8'h0f);
    ev[8 + k] <= 1;
    @(posedge core_clk_i);
    ev <= 0;
    bus(1, `LIA_IDX_SUM, 0);
    see(2'b11);
    rd(`LIA_IDX_SUM, 1 << k);
    bus(1, `LIA_IDX_MASK, 8'h0f);
    see(2'b10);
    rd(`LIA_IDX_EVT, 1 << k);
    rd(`LIA_IDX_EVT, 0);
    see(2'b00);
    bus(1, `LIA_IDX_MASK, 0);
    see(2'b01);
    r = seen;
    chk(1);
    bus(1, `LIA_IDX_ST0 + k, 0);
    {gov, cnt, fp} <= {1'b1, 4'h8, 4'h2};
    @(posedge core_clk_i);
    fp <= 0;
    rd(`LIA_IDX_ST0, 8'hc0);
    rd(`LIA_IDX_ST0 + 3, 8'h01);
    bus(1, `LIA_IDX_ST0, 0);
    rd(`LIA_IDX_ST0, 8'h80);
    {gov, cnt, rdy} <= {1'b0, 4'h0, 4'h4};
    @(posedge core_clk_i);
    rd(`LIA_IDX_ST0, 8'h40);
    rd(`LIA_IDX_ST0 + 1, 0);
    complete_run;
  end
endmodule // tb_top
